// file: tpfr_params.svh
// Command codes, field positions, reset values and widths for tpfr_top.
`ifndef TPFR_PARAMS_SVH
`define TPFR_PARAMS_SVH

// Command codes of the registers.
`define TPFR_CMD_OT_WARN   8'h51
`define TPFR_CMD_UT_WARN   8'h52
`define TPFR_CMD_UT_FAULT  8'h53
`define TPFR_CMD_UT_ACTION 8'h54

// Fault action byte fields.
`define TPFR_RESP_HI  7
`define TPFR_RESP_LO  6
`define TPFR_RETRY_HI 5
`define TPFR_RETRY_LO 3
`define TPFR_DELAY_HI 2
`define TPFR_DELAY_LO 0

// Retry codes with special meaning.
`define TPFR_RETRY_NONE    3'h0
`define TPFR_RETRY_FOREVER 3'h7

// Reset values.
`define TPFR_RST_OT_WARN   16'h0000
`define TPFR_RST_UT_WARN   16'h0000
`define TPFR_RST_UT_FAULT  16'h0000
`define TPFR_RST_UT_ACTION 8'h00

// Width of the signed fixed-point form of linear values.
`define TPFR_LIN_W 48

`endif

// file: tpfr_pkg.sv
// Types shared by the temperature limit and fault response block.
package tpfr_pkg;

    typedef enum logic [5:0] {
        ST_OFF   = 6'h01,
        ST_RUN   = 6'h02,
        ST_GRACE = 6'h04,
        ST_WAIT  = 6'h08,
        ST_HOLD  = 6'h10,
        ST_LATCH = 6'h20
    } tpfr_state_t;

    typedef enum logic [1:0] {
        RESP_IGNORE   = 2'h0,
        RESP_CONTINUE = 2'h1,
        RESP_RETRY    = 2'h2,
        RESP_RESUME   = 2'h3
    } tpfr_resp_t;

endpackage : tpfr_pkg

// file: tpfr_top.sv
// Temperature limit registers and under-temperature fault response.
`include "tpfr_params.svh"

module tpfr_top (
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        rst,
    // Register access by command code.
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_cmd,
    input  wire logic [15:0] reg_wdata,
    output logic      [15:0] reg_rdata_ff,
    output logic             reg_rvalid_ff,
    // Measurement and control.
    input  wire logic [15:0] temp_meas,
    input  wire logic [15:0] unit_cycles,
    input  wire logic        run_cmd,
    input  wire logic        other_fault,
    input  wire logic        fault_clear,
    // Status.
    output logic             out_enable,
    output logic             ot_warn_ff,
    output logic             ut_warn_ff,
    output logic             ut_fault_ff,
    output logic             restart_pulse_ff,
    output logic             latched_off
);

    // Linear value to signed fixed point with 16 fraction bits.
    function automatic logic signed [`TPFR_LIN_W-1:0] tpfr_lin(
        input logic [15:0] v);
        logic signed [`TPFR_LIN_W-1:0] m;
        logic [4:0]                    sh;
        m = `TPFR_LIN_W'(signed'(v[10:0]));
        sh = {~v[15], v[14:11]};
        tpfr_lin = m <<< sh;
    endfunction : tpfr_lin

    logic [15:0]           ot_thr_ff;
    logic [15:0]           utw_thr_ff;
    logic [15:0]           utf_thr_ff;
    logic [7:0]            action_ff;
    tpfr_pkg::tpfr_state_t state_ff;
    tpfr_pkg::tpfr_state_t nxt_state;
    logic [15:0]           unit_cnt_ff;
    logic [7:0]            timer_ff;
    logic [2:0]            tries_ff;
    logic [2:0]            nxt_tries;
    logic                  timer_load;
    logic                  unit_tick;
    logic                  expire;
    logic                  off_req;
    logic                  attempt;
    logic                  ot_cmp;
    logic                  utw_cmp;
    logic                  utf_cmp;
    logic [1:0]            resp;
    logic [2:0]            retry;
    logic [7:0]            mult;
    logic [15:0]           unit_last;

    assign resp  = action_ff[`TPFR_RESP_HI:`TPFR_RESP_LO];
    assign retry = action_ff[`TPFR_RETRY_HI:`TPFR_RETRY_LO];
    assign mult  = 8'h01 << action_ff[`TPFR_DELAY_HI:`TPFR_DELAY_LO];
    assign off_req = !run_cmd || other_fault;

    // Register writes.
    always_ff @(posedge clock) begin
        if (rst) begin
            ot_thr_ff  <= `TPFR_RST_OT_WARN;
            utw_thr_ff <= `TPFR_RST_UT_WARN;
            utf_thr_ff <= `TPFR_RST_UT_FAULT;
            action_ff  <= `TPFR_RST_UT_ACTION;
        end else if (reg_wr) begin
            case (reg_cmd)
                `TPFR_CMD_OT_WARN:   ot_thr_ff  <= reg_wdata;
                `TPFR_CMD_UT_WARN:   utw_thr_ff <= reg_wdata;
                `TPFR_CMD_UT_FAULT:  utf_thr_ff <= reg_wdata;
                `TPFR_CMD_UT_ACTION: action_ff  <= reg_wdata[7:0];
                default: ;
            endcase
        end
    end

    // Register reads; unknown codes read as zero.
    always_ff @(posedge clock) begin
        if (rst) begin
            reg_rdata_ff  <= 16'h0000;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rvalid_ff <= reg_rd;
            if (reg_rd) begin
                case (reg_cmd)
                    `TPFR_CMD_OT_WARN:   reg_rdata_ff <= ot_thr_ff;
                    `TPFR_CMD_UT_WARN:   reg_rdata_ff <= utw_thr_ff;
                    `TPFR_CMD_UT_FAULT:  reg_rdata_ff <= utf_thr_ff;
                    `TPFR_CMD_UT_ACTION: reg_rdata_ff <= {8'h00, action_ff};
                    default:             reg_rdata_ff <= 16'h0000;
                endcase
            end
        end
    end

    // Limit comparisons.
    assign ot_cmp  = tpfr_lin(temp_meas) > tpfr_lin(ot_thr_ff);
    assign utw_cmp = tpfr_lin(temp_meas) < tpfr_lin(utw_thr_ff);
    assign utf_cmp = tpfr_lin(temp_meas) < tpfr_lin(utf_thr_ff);

    always_ff @(posedge clock) begin
        if (rst) begin
            ot_warn_ff  <= 1'b0;
            ut_warn_ff  <= 1'b0;
            ut_fault_ff <= 1'b0;
        end else begin
            ot_warn_ff  <= ot_cmp;
            ut_warn_ff  <= utw_cmp;
            ut_fault_ff <= utf_cmp;
        end
    end

    // Delay unit divider; a zero setting acts as one cycle per unit.
    // Comparing by >= stops a shortened unit from wrapping the counter.
    assign unit_last = (unit_cycles == 16'h0000) ? 16'h0000
                                                 : unit_cycles - 16'h0001;
    assign unit_tick = (unit_cnt_ff >= unit_last);
    assign expire    = unit_tick && (timer_ff == 8'h01);

    always_ff @(posedge clock) begin
        if (rst || timer_load || unit_tick) begin
            unit_cnt_ff <= 16'h0000;
        end else begin
            unit_cnt_ff <= unit_cnt_ff + 16'h0001;
        end
    end

    // Restarting the divider on load makes each delay exactly mult units.
    always_ff @(posedge clock) begin
        if (rst) begin
            timer_ff <= 8'h00;
        end else if (timer_load) begin
            timer_ff <= mult;
        end else if (unit_tick && timer_ff != 8'h00) begin
            timer_ff <= timer_ff - 8'h01;
        end
    end

    // Fault response state machine.
    always_comb begin
        nxt_state  = state_ff;
        nxt_tries  = tries_ff;
        timer_load = 1'b0;
        attempt    = 1'b0;
        case (state_ff)
            tpfr_pkg::ST_OFF: begin
                if (!off_req) begin
                    nxt_state = tpfr_pkg::ST_RUN;
                end
            end
            tpfr_pkg::ST_RUN: begin
                nxt_tries = 3'h0;
                if (off_req) begin
                    nxt_state = tpfr_pkg::ST_OFF;
                end else if (ut_fault_ff) begin
                    case (resp)
                        tpfr_pkg::RESP_IGNORE: ;
                        tpfr_pkg::RESP_CONTINUE: begin
                            nxt_state  = tpfr_pkg::ST_GRACE;
                            timer_load = 1'b1;
                        end
                        tpfr_pkg::RESP_RETRY: begin
                            timer_load = 1'b1;
                            nxt_state  = (retry == `TPFR_RETRY_NONE)
                                       ? tpfr_pkg::ST_LATCH
                                       : tpfr_pkg::ST_WAIT;
                        end
                        default: nxt_state = tpfr_pkg::ST_HOLD;
                    endcase
                end
            end
            tpfr_pkg::ST_GRACE: begin
                if (off_req) begin
                    nxt_state = tpfr_pkg::ST_OFF;
                end else if (!ut_fault_ff) begin
                    nxt_state = tpfr_pkg::ST_RUN;
                end else if (expire) begin
                    timer_load = 1'b1;
                    nxt_state  = (retry == `TPFR_RETRY_NONE)
                               ? tpfr_pkg::ST_LATCH
                               : tpfr_pkg::ST_WAIT;
                end
            end
            tpfr_pkg::ST_WAIT: begin
                if (off_req) begin
                    nxt_state = tpfr_pkg::ST_OFF;
                end else if (expire) begin
                    attempt = 1'b1;
                    if (!ut_fault_ff) begin
                        nxt_state = tpfr_pkg::ST_RUN;
                    end else if (retry == `TPFR_RETRY_FOREVER) begin
                        timer_load = 1'b1;
                    end else if (tries_ff + 3'h1 >= retry) begin
                        nxt_state = tpfr_pkg::ST_LATCH;
                    end else begin
                        nxt_tries  = tries_ff + 3'h1;
                        timer_load = 1'b1;
                    end
                end
            end
            tpfr_pkg::ST_HOLD: begin
                if (off_req) begin
                    nxt_state = tpfr_pkg::ST_OFF;
                end else if (!ut_fault_ff) begin
                    nxt_state = tpfr_pkg::ST_RUN;
                end
            end
            tpfr_pkg::ST_LATCH: begin
                if (fault_clear) begin
                    nxt_state = tpfr_pkg::ST_OFF;
                end
            end
            default: nxt_state = tpfr_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= tpfr_pkg::ST_OFF;
            tries_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            tries_ff <= nxt_tries;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            restart_pulse_ff <= 1'b0;
        end else begin
            restart_pulse_ff <= attempt;
        end
    end

    assign out_enable  = (state_ff == tpfr_pkg::ST_RUN)
                      || (state_ff == tpfr_pkg::ST_GRACE);
    assign latched_off = (state_ff == tpfr_pkg::ST_LATCH);

    // Checks.
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_retry_fault;
        state_ff == tpfr_pkg::ST_RUN && !off_req && ut_fault_ff
            && resp == tpfr_pkg::RESP_RETRY;
    endsequence

    a_ot_thr_store: assert property (
        reg_wr && reg_cmd == `TPFR_CMD_OT_WARN ##1 reg_rd
            && reg_cmd == `TPFR_CMD_OT_WARN
        |=> reg_rvalid_ff && reg_rdata_ff == $past(reg_wdata, 2))
        else $error("over-temperature threshold not read back");
    a_utw_read: assert property (
        reg_rd && reg_cmd == `TPFR_CMD_UT_WARN
        |=> reg_rdata_ff == $past(utw_thr_ff))
        else $error("under-temperature warning read wrong");
    a_ut_fault_det: assert property (
        utf_cmp |=> ut_fault_ff)
        else $error("under-temperature fault not flagged");
    a_ot_warn_flag: assert property (
        $rose(ot_warn_ff) |-> $past(ot_cmp))
        else $error("warning raised without cause");
    a_ignore_run: assert property (
        state_ff == tpfr_pkg::ST_RUN && !off_req
            && resp == tpfr_pkg::RESP_IGNORE |=> out_enable)
        else $error("ignored fault stopped the output");
    a_grace_on: assert property (
        state_ff == tpfr_pkg::ST_GRACE && !off_req && !expire |=> out_enable)
        else $error("output dropped during delay");
    a_grace_end: assert property (
        state_ff == tpfr_pkg::ST_GRACE && !off_req && ut_fault_ff && expire
        |=> !out_enable)
        else $error("output kept on after the delay");
    a_retry_off: assert property (
        s_retry_fault |=> !out_enable ##0 timer_ff == $past(mult))
        else $error("disable and retry did not disable");
    a_resume_ok: assert property (
        state_ff == tpfr_pkg::ST_HOLD && !off_req && !ut_fault_ff
        |=> out_enable)
        else $error("output did not resume");
    a_latch_stays: assert property (
        latched_off && !fault_clear |=> latched_off && !out_enable)
        else $error("latched off left without clear");
    a_tries_bound: assert property (
        state_ff == tpfr_pkg::ST_WAIT && retry != `TPFR_RETRY_FOREVER
        |-> tries_ff < retry)
        else $error("retry count exceeded");
    a_forever_wait: assert property (
        state_ff == tpfr_pkg::ST_WAIT && expire && ut_fault_ff
            && !off_req && retry == `TPFR_RETRY_FOREVER
        |=> state_ff == tpfr_pkg::ST_WAIT && timer_ff == $past(mult))
        else $error("continuous retry stopped");

endmodule : tpfr_top

// file: tpfr_host.sv
// Host model that reads and writes the registers by command code.
module tpfr_host (
    // Clock.
    input  wire logic        clock,
    // Register port.
    output logic             reg_wr,
    output logic             reg_rd,
    output logic [7:0]       reg_cmd,
    output logic [15:0]      reg_wdata,
    input  wire logic [15:0] reg_rdata_ff,
    input  wire logic        reg_rvalid_ff
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_cmd = 8'h00;
        reg_wdata = 16'h0000;
    end

    task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
        @(negedge clock);
        reg_cmd = cmd;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        // Released data is inverted so a stale value cannot pass.
        reg_wdata = ~d;
    endtask : wr

    // Write followed at once by a read of the same code, back to back.
    task automatic wr_rd(input logic [7:0] cmd, input logic [15:0] wd,
                         output logic [15:0] d);
        @(negedge clock);
        reg_cmd = cmd;
        reg_wdata = wd;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_wdata = ~wd;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d = 16'hDEAD;
        if (reg_rvalid_ff === 1'b1) begin
            d = reg_rdata_ff;
        end
    endtask : wr_rd

    task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
        @(negedge clock);
        reg_cmd = cmd;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        d = 16'hDEAD;
        for (int i = 0; i < 4; i++) begin
            if (reg_rvalid_ff === 1'b1) begin
                d = reg_rdata_ff;
                break;
            end
            @(negedge clock);
        end
    endtask : rd
endmodule : tpfr_host

// file: tpfr_tb.sv
// Self-checking testbench for the temperature limits and fault response.
`include "tpfr_params.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [15:0] NORM = 16'h0019;
    localparam logic [15:0] COLD = 16'h0002;
    logic        clock;
    logic        rst;
    logic        run_cmd;
    logic        other_fault;
    logic        fault_clear;
    logic [15:0] temp_meas;
    logic [15:0] unit_cycles;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_cmd;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata_ff;
    logic        reg_rvalid_ff;
    logic        out_enable;
    logic        ot_warn_ff;
    logic        ut_warn_ff;
    logic        ut_fault_ff;
    logic        restart_pulse_ff;
    logic        latched_off;
    int          n_mismatch;
    int          check_count;
    int          pulses;
    int          on_cyc;
    int          gap;

    tpfr_host host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff));

    tpfr_top dut (.clock(clock), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_cmd(reg_cmd), .reg_wdata(reg_wdata),
        .reg_rdata_ff(reg_rdata_ff), .reg_rvalid_ff(reg_rvalid_ff),
        .temp_meas(temp_meas), .unit_cycles(unit_cycles),
        .run_cmd(run_cmd), .other_fault(other_fault),
        .fault_clear(fault_clear), .out_enable(out_enable),
        .ot_warn_ff(ot_warn_ff), .ut_warn_ff(ut_warn_ff),
        .ut_fault_ff(ut_fault_ff), .restart_pulse_ff(restart_pulse_ff),
        .latched_off(latched_off));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up

    // Counts output-on cycles and restart pulses, and the last pulse gap.
    task automatic watch(input int n);
        int last;
        last = 0;
        pulses = 0;
        on_cyc = 0;
        gap = 0;
        for (int i = 1; i <= n; i++) begin
            @(negedge clock);
            if (out_enable === 1'b1) on_cyc++;
            if (restart_pulse_ff === 1'b1) begin
                if (last != 0) gap = i - last;
                last = i;
                pulses++;
            end
        end
    endtask : watch

    task automatic fault(input logic [7:0] act, input logic [15:0] unit,
                         input int n);
        host.wr(`TPFR_CMD_UT_ACTION, {8'h00, act});
        unit_cycles = unit;
        temp_meas = COLD;
        watch(n);
    endtask : fault

    task automatic recover();
        temp_meas = NORM;
        fault_clear = 1'b1;
        @(negedge clock);
        fault_clear = 1'b0;
        repeat (4) @(negedge clock);
        check(16'(out_enable), 16'h0001);
        check(16'(latched_off), 16'h0000);
    endtask : recover

    task automatic t_regs();
        logic [7:0]  cmd [5] = '{`TPFR_CMD_OT_WARN, `TPFR_CMD_UT_WARN,
            `TPFR_CMD_UT_FAULT, `TPFR_CMD_UT_ACTION, 8'h55};
        logic [15:0] val [5] = '{16'h0050, 16'h000A, 16'h0005, 16'h12A5,
            16'h7777};
        logic [15:0] exp [5] = '{16'h0050, 16'h000A, 16'h0005, 16'h00A5,
            16'h0000};
        logic [15:0] d;
        for (int i = 0; i < 5; i++) begin
            host.rd(cmd[i], d);
            check(d, 16'h0000);
            if (i == 0) begin
                host.wr_rd(cmd[i], val[i], d);
            end else begin
                host.wr(cmd[i], val[i]);
                host.rd(cmd[i], d);
            end
            check(d, exp[i]);
        end
        $display("t_regs done");
    endtask : t_regs

    task automatic t_warn();
        temp_meas = 16'h0064;
        repeat (3) @(negedge clock);
        check(16'({ot_warn_ff, ut_warn_ff, ut_fault_ff}), 16'h0004);
        temp_meas = 16'h0007;
        repeat (3) @(negedge clock);
        check(16'({ot_warn_ff, ut_warn_ff, ut_fault_ff}), 16'h0002);
        temp_meas = NORM;
        $display("t_warn done");
    endtask : t_warn

    task automatic t_ignore();
        fault(8'h3F, 16'h0001, 40);
        check(16'(ut_fault_ff), 16'h0001);
        check(16'(on_cyc), 16'd40);
        check(16'(pulses), 16'h0000);
        temp_meas = NORM;
        $display("t_ignore done");
    endtask : t_ignore

    task automatic t_retry();
        int n [3] = '{0, 2, 6};
        for (int k = 0; k < 3; k++) begin
            fault(8'h81 | 8'(n[k] << 3), 16'h0002, n[k] * 4 + 30);
            check(16'(pulses), 16'(n[k]));
            check(16'(on_cyc < 4), 16'h0001);
            check(16'(latched_off), 16'h0001);
            if (n[k] > 1) check(16'(gap), 16'h0004);
            recover();
        end
        $display("t_retry done");
    endtask : t_retry

    task automatic t_continue();
        fault(8'h47, 16'h0001, 140);
        check(16'(on_cyc >= 128 && on_cyc <= 132), 16'h0001);
        check(16'(latched_off), 16'h0001);
        recover();
        fault(8'h48, 16'h0001, 20);
        check(16'(pulses), 16'h0001);
        check(16'(latched_off), 16'h0001);
        recover();
        $display("t_continue done");
    endtask : t_continue

    task automatic t_resume();
        fault(8'hC0, 16'h0001, 30);
        check(16'(on_cyc < 4), 16'h0001);
        temp_meas = NORM;
        watch(10);
        check(16'(on_cyc >= 6), 16'h0001);
        check(16'(latched_off), 16'h0000);
        $display("t_resume done");
    endtask : t_resume

    task automatic t_forever();
        fault(8'hB8, 16'h0003, 60);
        check(16'(pulses >= 15), 16'h0001);
        check(16'(gap), 16'h0003);
        run_cmd = 1'b0;
        watch(12);
        check(16'(pulses + on_cyc), 16'h0000);
        run_cmd = 1'b1;
        other_fault = 1'b1;
        watch(12);
        check(16'(pulses + on_cyc), 16'h0000);
        other_fault = 1'b0;
        recover();
        $display("t_forever done");
    endtask : t_forever

    initial begin
        n_mismatch = 0;
        check_count = 0;
        rst = 1'b1;
        run_cmd = 1'b1;
        other_fault = 1'b0;
        fault_clear = 1'b0;
        temp_meas = NORM;
        unit_cycles = 16'h0001;
        repeat (20) @(negedge clock);
        rst = 1'b0;
        t_regs();
        t_warn();
        t_ignore();
        t_retry();
        t_continue();
        t_resume();
        t_forever();
        wrap_up();
    end

    initial begin
        #100us;
        n_mismatch++;
        wrap_up();
    end
endmodule : tb
